//--- hdl/psm_regs.sv
// Pin snapshot, address base, identity, discharge interlock and shared pin status
// Behaviour
// - Input fields come from two-stage synchronised pads, unfiltered
// - Bit 15 low while pulling power-good low
// - Bit 14 low while pulling alert low
// - Bits 13:10 show own fault pin pull-downs
// - Bits 9:8 encode address select 1 three-state
// - Bits 7:6 encode address select 0 three-state
// - Bits 5:4 show on/off input levels
// - Bits 3:0 show fault pin input levels
// - Device address is base plus offset 0-9
// - Base holds 7 bits, bit 7 reads zero
// - Fixed 16-bit read-only part identity
// - Per-page 8-bit factory lot number
// - Off threshold is coefficient times setpoint
// - Turn-on at or above threshold sets flag, pulls alert
// - Channel stays off until below threshold
// - Coefficient above one skips discharge check
// - Coefficient stored as 16-bit short float
// - Undischarged output holds others via fault pins
// - Bit 1 high when share clock held low
// - Bit 0 shows write-protect pin level
// - Shared pin status bits 7:2 read zero
`timescale 1ns/1ps
module psm_regs
  import psm_pkg::*;
#(
  parameter logic [15:0] PART_ID = 16'h5a3c,  // Arbitrary identity value
  parameter logic [63:0] LOT_NUM = 64'h0706050403020100  // Arbitrary, byte per page
) (
  // Clock and reset
  input  wire logic                    SYS_CLK_I,
  input  wire logic                    SYS_RST_I,
  // Management command port
  input  wire logic                    CMD_VALID_I,
  input  wire logic                    CMD_WRITE_I,
  input  wire logic [7:0]              CMD_CODE_I,
  input  wire logic [2:0]              CMD_PAGE_I,
  input  wire logic [15:0]             CMD_WDATA_I,
  output logic                         RSP_VALID_O,
  output logic                         RSP_ERR_O,
  output logic [15:0]                  RSP_DATA_O,
  // Device address
  input  wire logic [3:0]              ADDR_OFS_I,
  input  wire logic [6:0]              BUS_ADDR_I,
  output logic [6:0]                   DEV_ADDR_O,
  output logic                         ADDR_HIT_O,
  // Slow pads
  input  wire logic [NUM_FAULT-1:0]    FAULT_SHARE_PIN_I,
  output logic [NUM_FAULT-1:0]         FAULT_SHARE_PIN_O,
  output logic [NUM_FAULT-1:0]         FAULT_SHARE_PIN_OE_O,
  output logic                         ALERT_N_O,
  output logic                         ALERT_N_OE_O,
  output logic                         PWR_GOOD_O,
  output logic                         PWR_GOOD_OE_O,
  input  wire logic                    ADDRESS_SELECT_PIN_0_LVL_I,
  input  wire logic                    ADDRESS_SELECT_PIN_0_FLOAT_I,
  input  wire logic                    ADDRESS_SELECT_PIN_1_LVL_I,
  input  wire logic                    ADDRESS_SELECT_PIN_1_FLOAT_I,
  input  wire logic                    ON_OFF_INPUT_0_I,
  input  wire logic                    ON_OFF_INPUT_1_I,
  input  wire logic                    WRITE_LOCK_PIN_I,
  input  wire logic                    SHARE_CLK_PIN_I,
  // Requests from neighbouring device logic
  input  wire logic                    PG_PULL_LOW_I,
  input  wire logic                    ALERT_REQ_I,
  // Channel control
  input  wire logic [NUM_CH-1:0]       CH_ON_REQ_I,
  input  wire logic [NUM_CH-1:0][15:0] VOUT_CMD_I,
  input  wire logic [NUM_CH-1:0][15:0] VOUT_MEAS_I,
  output logic [NUM_CH-1:0]            CH_ENABLE_O,
  output logic [NUM_CH-1:0]            DISCH_PENDING_O
);

  // Synchroniser bit order
  localparam int SY_FIN  = 0;
  localparam int SY_C0   = 4;
  localparam int SY_C1   = 5;
  localparam int SY_A0L  = 6;
  localparam int SY_A0F  = 7;
  localparam int SY_A1L  = 8;
  localparam int SY_A1F  = 9;
  localparam int SY_WP   = 10;
  localparam int SY_SCLK = 11;
  localparam int SY_W    = 12;

  // Short float coefficient times setpoint, unsigned result
  function automatic logic [63:0] sf_scale(input logic [15:0] coef, input logic [15:0] val);
    logic signed [4:0]  ex;
    logic signed [10:0] mt;
    logic [63:0]        prod;
    ex   = coef[15:SF_EXP_LSB];
    mt   = coef[SF_MANT_MSB:0];
    prod = '0;
    if (mt > 0) begin
      prod = 64'(mt) * 64'(val);
      if (ex >= 0) begin
        prod = prod << 5'(ex);
      end else begin
        prod = prod >> 5'(-ex);
      end
    end
    return prod;
  endfunction

  // True when the short float value exceeds one, compared at 2^15 scale to keep fractions
  function automatic logic sf_above_one(input logic [15:0] coef);
    return sf_scale(coef, 16'h8000) > 64'h0000_0000_0000_8000;
  endfunction

  // Three-state address select code
  function automatic logic [1:0] asel_code(input logic lvl, input logic flt);
    logic [1:0] c;
    if (flt) begin
      c = ASEL_FLOAT;
    end else if (lvl) begin
      c = ASEL_HIGH;
    end else begin
      c = ASEL_LOW;
    end
    return c;
  endfunction

  logic [SY_W-1:0]              sync1_r;
  logic [SY_W-1:0]              sync2_r;
  logic                         sclk_prev_r;
  logic [SHARE_CNT_W-1:0]       sclk_cnt_r;
  logic                         sclk_low_r;
  logic [6:0]                   addr_base_r;
  logic [NUM_CH-1:0][15:0]      coef_r;
  logic [7:0]                   share_mask_r;
  logic [NUM_CH-1:0]            pend_r;
  logic [NUM_CH-1:0]            pend_set;
  logic [NUM_CH-1:0]            pend_clr;
  psm_ch_state_type             ch_st_r [NUM_CH];
  psm_ch_state_type             ch_st_nxt [NUM_CH];
  logic [NUM_CH-1:0]            above;
  logic [NUM_CH-1:0]            check_en;
  logic [NUM_CH-1:0]            held_off;
  logic [NUM_FAULT-1:0]         fault_drive;
  logic [15:0]                  pad_word;
  logic [15:0]                  rd_data;
  logic                         rd_ok;
  logic                         wr_ok;
  logic [3:0]                   ofs_sat;
  logic [15:0]                  rsp_data_r;
  logic                         rsp_valid_r;
  logic                         rsp_err_r;

  // Two-stage pin synchroniser, no deglitch
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= {SHARE_CLK_PIN_I, WRITE_LOCK_PIN_I,
                  ADDRESS_SELECT_PIN_1_FLOAT_I, ADDRESS_SELECT_PIN_1_LVL_I,
                  ADDRESS_SELECT_PIN_0_FLOAT_I, ADDRESS_SELECT_PIN_0_LVL_I,
                  ON_OFF_INPUT_1_I, ON_OFF_INPUT_0_I, FAULT_SHARE_PIN_I};
      sync2_r <= sync1_r;
    end
  end

  // Share clock idle detector
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      sclk_prev_r <= 1'b0;
      sclk_cnt_r  <= '0;
      sclk_low_r  <= 1'b1;
    end else begin
      sclk_prev_r <= sync2_r[SY_SCLK];
      if (sync2_r[SY_SCLK] != sclk_prev_r || sync2_r[SY_SCLK]) begin
        sclk_cnt_r <= '0;
        sclk_low_r <= 1'b0;
      end else if (sclk_cnt_r == SHARE_CNT_W'(SHARE_LOW_CYC - 1)) begin
        sclk_low_r <= 1'b1;
      end else begin
        sclk_cnt_r <= sclk_cnt_r + 1'b1;
      end
    end
  end

  // Device address from base and saturated offset
  assign ofs_sat    = (ADDR_OFS_I > ADDR_OFS_MAX) ? ADDR_OFS_MAX : ADDR_OFS_I;
  assign DEV_ADDR_O = addr_base_r + {3'h0, ofs_sat};
  assign ADDR_HIT_O = (BUS_ADDR_I == DEV_ADDR_O);

  // Per-channel threshold compare and interlock inputs
  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      above[c]    = 64'(VOUT_MEAS_I[c]) >= sf_scale(coef_r[c], VOUT_CMD_I[c]);
      check_en[c] = !sf_above_one(coef_r[c]);
      held_off[c] = !sync2_r[SY_FIN + c / 2];
    end
  end

  // Channel turn-on state machines
  always_comb begin
    pend_set = '0;
    for (int c = 0; c < NUM_CH; c++) begin
      ch_st_nxt[c] = ch_st_r[c];
      case (ch_st_r[c])
        CH_OFF: begin
          if (CH_ON_REQ_I[c]) begin
            if (check_en[c] && above[c]) begin
              ch_st_nxt[c] = CH_WAIT;
              pend_set[c]  = 1'b1;
            end else if (!held_off[c]) begin
              ch_st_nxt[c] = CH_ON;
            end
          end
        end
        CH_WAIT: begin
          if (!CH_ON_REQ_I[c]) begin
            ch_st_nxt[c] = CH_OFF;
          end else if ((!above[c] || !check_en[c]) && !held_off[c]) begin
            ch_st_nxt[c] = CH_ON;
          end
        end
        CH_ON: begin
          if (!CH_ON_REQ_I[c]) begin
            ch_st_nxt[c] = CH_OFF;
          end
        end
        default: begin
          ch_st_nxt[c] = CH_OFF;
        end
      endcase
    end
  end

  // Channel state registers
  always_ff @(posedge SYS_CLK_I) begin
    for (int c = 0; c < NUM_CH; c++) begin
      if (SYS_RST_I) begin
        ch_st_r[c] <= CH_OFF;
      end else begin
        ch_st_r[c] <= ch_st_nxt[c];
      end
    end
  end

  // Enable outputs; fault pin pull-down only while a masked channel is undischarged,
  // so a waiting channel never holds itself off once it has decayed
  always_comb begin
    fault_drive = '0;
    for (int c = 0; c < NUM_CH; c++) begin
      CH_ENABLE_O[c] = (ch_st_r[c] == CH_ON);
      if (ch_st_r[c] == CH_WAIT && share_mask_r[c] && check_en[c] && above[c]) begin
        fault_drive[c / 2] = 1'b1;
      end
    end
  end

  // Open-drain pads: data low, enable pulls
  assign FAULT_SHARE_PIN_O    = '0;
  assign FAULT_SHARE_PIN_OE_O = fault_drive;
  assign ALERT_N_O            = 1'b0;
  assign ALERT_N_OE_O         = (|pend_r) | ALERT_REQ_I;
  assign PWR_GOOD_O           = 1'b0;
  assign PWR_GOOD_OE_O        = PG_PULL_LOW_I;
  assign DISCH_PENDING_O      = pend_r;

  // Pad snapshot word, fault pin order reversed to bit order
  always_comb begin
    pad_word = '0;
    pad_word[PAD_PG_BIT]    = !PWR_GOOD_OE_O;
    pad_word[PAD_ALERT_BIT] = !ALERT_N_OE_O;
    for (int k = 0; k < NUM_FAULT; k++) begin
      pad_word[PAD_FDRV_LSB + NUM_FAULT - 1 - k] = !fault_drive[k];
      pad_word[PAD_FIN_LSB + NUM_FAULT - 1 - k]  = sync2_r[SY_FIN + k];
    end
    pad_word[PAD_ADDRESS_SELECT_PIN_1_LSB +: 2] = asel_code(sync2_r[SY_A1L], sync2_r[SY_A1F]);
    pad_word[PAD_ADDRESS_SELECT_PIN_0_LSB +: 2] = asel_code(sync2_r[SY_A0L], sync2_r[SY_A0F]);
    pad_word[PAD_CTRL1_BIT] = sync2_r[SY_C1];
    pad_word[PAD_CTRL0_BIT] = sync2_r[SY_C0];
  end

  // Read decode
  always_comb begin
    rd_data = '0;
    rd_ok   = 1'b1;
    if (CMD_CODE_I == CMD_PAD_SNAPSHOT) begin
      rd_data = pad_word;
    end else if (CMD_CODE_I == CMD_ADDR_BASE) begin
      rd_data = {9'h000, addr_base_r};
    end else if (CMD_CODE_I == CMD_PART_ID) begin
      rd_data = PART_ID;
    end else if (CMD_CODE_I == CMD_LOT_NUMBER) begin
      rd_data = {8'h00, LOT_NUM[CMD_PAGE_I * 8 +: 8]};
    end else if (CMD_CODE_I == CMD_DISCH_COEF) begin
      rd_data = coef_r[CMD_PAGE_I];
    end else if (CMD_CODE_I == CMD_SHARED_PINS) begin
      rd_data[SHR_CLK_BIT] = sclk_low_r;
      rd_data[SHR_WP_BIT]  = sync2_r[SY_WP];
    end else if (CMD_CODE_I == CMD_VENDOR_STAT) begin
      rd_data[VSTAT_DISCH_BIT] = pend_r[CMD_PAGE_I];
    end else if (CMD_CODE_I == CMD_SHARE_MASK) begin
      rd_data = {8'h00, share_mask_r};
    end else begin
      rd_ok = 1'b0;
    end
  end

  // Writable codes, refused while write-protect pin is high
  assign wr_ok = !sync2_r[SY_WP] &&
                 (CMD_CODE_I == CMD_ADDR_BASE || CMD_CODE_I == CMD_DISCH_COEF ||
                  CMD_CODE_I == CMD_VENDOR_STAT || CMD_CODE_I == CMD_SHARE_MASK);

  // Writable registers
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      addr_base_r  <= ADDR_BASE_RST;
      share_mask_r <= SHARE_MASK_RST;
      for (int c = 0; c < NUM_CH; c++) begin
        coef_r[c] <= COEF_RST;
      end
    end else if (CMD_VALID_I && CMD_WRITE_I && wr_ok) begin
      if (CMD_CODE_I == CMD_ADDR_BASE) begin
        addr_base_r <= CMD_WDATA_I[ADDR_W-1:0];
      end else if (CMD_CODE_I == CMD_DISCH_COEF) begin
        coef_r[CMD_PAGE_I] <= CMD_WDATA_I;
      end else if (CMD_CODE_I == CMD_SHARE_MASK) begin
        share_mask_r <= CMD_WDATA_I[7:0];
      end
    end
  end

  // Discharge pending clear by writing one to the page flag
  always_comb begin
    pend_clr = '0;
    if (CMD_VALID_I && CMD_WRITE_I && wr_ok && CMD_CODE_I == CMD_VENDOR_STAT) begin
      pend_clr[CMD_PAGE_I] = CMD_WDATA_I[VSTAT_DISCH_BIT];
    end
  end

  // Sticky discharge flags, set wins over clear
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      pend_r <= '0;
    end else begin
      pend_r <= (pend_r & ~pend_clr) | pend_set;
    end
  end

  // Response registers, one cycle after the command
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      rsp_valid_r <= 1'b0;
      rsp_err_r   <= 1'b0;
      rsp_data_r  <= '0;
    end else begin
      rsp_valid_r <= CMD_VALID_I;
      if (CMD_VALID_I) begin
        rsp_err_r  <= CMD_WRITE_I ? !wr_ok : !rd_ok;
        rsp_data_r <= CMD_WRITE_I ? 16'h0000 : rd_data;
      end
    end
  end

  assign RSP_VALID_O = rsp_valid_r;
  assign RSP_ERR_O   = rsp_err_r;
  assign RSP_DATA_O  = rsp_data_r;

endmodule

//--- hdl/psm_pkg.sv
// Constants and types for the pin status, identity and discharge register group
package psm_pkg;
  // Channel and pin counts
  localparam int NUM_CH    = 8;
  localparam int NUM_FAULT = 4;
  // Command codes of this register group
  localparam logic [7:0] CMD_PAD_SNAPSHOT = 8'he0;
  localparam logic [7:0] CMD_ADDR_BASE    = 8'he1;
  localparam logic [7:0] CMD_PART_ID      = 8'he2;
  localparam logic [7:0] CMD_LOT_NUMBER   = 8'he3;
  localparam logic [7:0] CMD_DISCH_COEF   = 8'he4;
  localparam logic [7:0] CMD_SHARED_PINS  = 8'he5;
  localparam logic [7:0] CMD_VENDOR_STAT  = 8'he6;
  localparam logic [7:0] CMD_SHARE_MASK   = 8'he7;
  // Pad snapshot field positions
  localparam int PAD_PG_BIT      = 15;
  localparam int PAD_ALERT_BIT   = 14;
  localparam int PAD_FDRV_LSB    = 10;
  localparam int PAD_ADDRESS_SELECT_PIN_1_LSB   = 8;
  localparam int PAD_ADDRESS_SELECT_PIN_0_LSB   = 6;
  localparam int PAD_CTRL1_BIT   = 5;
  localparam int PAD_CTRL0_BIT   = 4;
  localparam int PAD_FIN_LSB     = 0;
  // Three-state address select codes
  localparam logic [1:0] ASEL_HIGH  = 2'h3;
  localparam logic [1:0] ASEL_FLOAT = 2'h2;
  localparam logic [1:0] ASEL_LOW   = 2'h0;
  // Shared pin status field positions
  localparam int SHR_CLK_BIT = 1;
  localparam int SHR_WP_BIT  = 0;
  // Vendor status discharge flag position
  localparam int VSTAT_DISCH_BIT = 0;
  // Address base and offset
  localparam int            ADDR_W        = 7;
  localparam logic [6:0]    ADDR_BASE_RST = 7'h5c;
  localparam logic [3:0]    ADDR_OFS_MAX  = 4'h9;
  // Discharge coefficient reset: 0.5 in short float format
  localparam logic [15:0]   COEF_RST      = 16'hf002;
  localparam logic [7:0]    SHARE_MASK_RST = 8'hff;
  // Short float format fields
  localparam int SF_EXP_LSB  = 11;
  localparam int SF_MANT_MSB = 10;
  // Share-clock idle time before it counts as held low
  localparam int CLK_MHZ          = 200;
  localparam int SHARE_LOW_NS     = 10000;
  localparam int SHARE_LOW_CYC    = (SHARE_LOW_NS * CLK_MHZ) / 1000;
  localparam int SHARE_CNT_W      = 12;
  // Channel turn-on states
  typedef enum logic [1:0] {CH_OFF, CH_WAIT, CH_ON} psm_ch_state_type;
endpackage

//--- test/psm_regs_asserts.sv
// Port-level checks for the register group
`timescale 1ns/1ps
module psm_regs_asserts
  import psm_pkg::*;
#(
  parameter logic [15:0] PART_ID = 16'h5a3c  // Arbitrary identity value
) (
  // Clock, reset, command port
  input wire logic                 SYS_CLK_I,
  input wire logic                 SYS_RST_I,
  input wire logic                 CMD_VALID_I,
  input wire logic                 CMD_WRITE_I,
  input wire logic [7:0]           CMD_CODE_I,
  input wire logic                 RSP_VALID_O,
  input wire logic [15:0]          RSP_DATA_O,
  // Pads and channels
  input wire logic [NUM_FAULT-1:0] FAULT_SHARE_PIN_O,
  input wire logic [NUM_FAULT-1:0] FAULT_SHARE_PIN_OE_O,
  input wire logic                 ALERT_N_O,
  input wire logic                 ALERT_N_OE_O,
  input wire logic                 PWR_GOOD_OE_O,
  input wire logic [NUM_CH-1:0]    CH_ON_REQ_I,
  input wire logic [NUM_CH-1:0]    CH_ENABLE_O,
  input wire logic [NUM_CH-1:0]    DISCH_PENDING_O
);
  // Read decode and pin-order reversal
  logic       rd;
  logic [3:0] fdrv;
  assign rd   = CMD_VALID_I && !CMD_WRITE_I;
  assign fdrv = {FAULT_SHARE_PIN_OE_O[0], FAULT_SHARE_PIN_OE_O[1],
                 FAULT_SHARE_PIN_OE_O[2], FAULT_SHARE_PIN_OE_O[3]};
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (SYS_RST_I);
  a_rsp_follows: assert property (CMD_VALID_I |=> RSP_VALID_O)
    else $error("answer missing after command");
  a_rsp_cause: assert property (RSP_VALID_O |-> $past(CMD_VALID_I))
    else $error("answer without command");
  a_pg_drive: assert property (
    rd && CMD_CODE_I == CMD_PAD_SNAPSHOT |=> RSP_DATA_O[15] == !$past(PWR_GOOD_OE_O))
    else $error("power-good drive bit wrong");
  a_alert_drive: assert property (
    rd && CMD_CODE_I == CMD_PAD_SNAPSHOT |=> RSP_DATA_O[14] == !$past(ALERT_N_OE_O))
    else $error("alert drive bit wrong");
  a_fault_drive: assert property (
    rd && CMD_CODE_I == CMD_PAD_SNAPSHOT |=> RSP_DATA_O[13:10] == ~$past(fdrv))
    else $error("fault drive bits wrong");
  a_base_top_zero: assert property (
    rd && CMD_CODE_I == CMD_ADDR_BASE |=> RSP_DATA_O[15:7] == 9'h000)
    else $error("address base upper bits set");
  a_id_fixed: assert property (rd && CMD_CODE_I == CMD_PART_ID |=> RSP_DATA_O == PART_ID)
    else $error("identity value wrong");
  a_shared_zero: assert property (
    rd && CMD_CODE_I == CMD_SHARED_PINS |=> RSP_DATA_O[15:2] == 14'h0000)
    else $error("shared status reserved bits set");
  a_alert_pending: assert property (
    $past(|DISCH_PENDING_O) && |DISCH_PENDING_O |-> ALERT_N_OE_O)
    else $error("pending flag without alert drive");
  a_on_needs_req: assert property ((CH_ENABLE_O & ~$past(CH_ON_REQ_I)) == 8'h00)
    else $error("channel on without request");
  a_open_drain: assert property (FAULT_SHARE_PIN_O == 4'h0 && !ALERT_N_O)
    else $error("open-drain pin driven high");
endmodule

//--- test/psm_host_model.sv
// Management host model: issues one command, captures the answer
`timescale 1ns/1ps
module psm_host_model (
  // Clock and request from the bench
  input  wire logic        clk_i,
  input  wire logic [28:0] req_i,
  // Command port toward the device
  output logic             cmd_valid_o,
  output logic             cmd_write_o,
  output logic [7:0]       cmd_code_o,
  output logic [2:0]       cmd_page_o,
  output logic [15:0]      cmd_wdata_o,
  // Answer from the device
  input  wire logic        rsp_valid_i,
  input  wire logic        rsp_err_i,
  input  wire logic [15:0] rsp_data_i,
  output logic             done_o,
  output logic             err_o,
  output logic [15:0]      rdata_o
);
  // One-cycle strobe with its fields, changed just after an edge
  always_ff @(posedge clk_i) begin
    {cmd_valid_o, cmd_write_o, cmd_code_o, cmd_page_o, cmd_wdata_o} <= req_i;
  end
  // Answer taken at the edge where its strobe is sampled
  always_ff @(posedge clk_i) begin
    done_o <= rsp_valid_i;
    if (rsp_valid_i) begin
      {err_o, rdata_o} <= {rsp_err_i, rsp_data_i};
    end
  end
endmodule

//--- test/psm_regs_tb_top.sv
// Self-checking bench for the pad, identity and discharge registers
`timescale 1ns/1ps
module psm_regs_tb_top;
  import psm_pkg::*;
  // Bench signals
  logic                    clk, rst, c_vld, c_wr, r_vld, r_err, h_done, h_err;
  logic                    shclk, hit, al_o, al_oe, pg_o, pg_oe;
  logic [28:0]             req;
  logic [7:0]              c_code;
  logic [2:0]              c_page;
  logic [15:0]             c_wd, r_data, h_data;
  logic [3:0]              ofs, fault_ext, f_o, f_oe;
  logic [6:0]              bus_addr, dev_addr;
  logic [8:0]              pads;
  logic [NUM_CH-1:0]       ch_req, ch_en, pend;
  logic [NUM_CH-1:0][15:0] vcmd, vmeas;
  int                      bad_count, checks_done;
  // Compare one value
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Counts, verdict, end of run
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // One command through the host model, bounded wait for its answer
  task automatic cmd(input logic w, input logic [7:0] c, input logic [2:0] p,
                     input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clk);
    req <= {1'b1, w, c, p, d};
    @(posedge clk);
    req <= '0;
    do begin
      @(negedge clk);
      n++;
    end while (h_done !== 1'b1 && n < 20);
    if (h_done !== 1'b1) begin
      bad_count++;
      summarize();
    end
  endtask
  // Read and compare data and error flag
  task automatic rd(input logic [7:0] c, input logic [2:0] p, input logic [15:0] e,
                    input logic er);
    cmd(1'b0, c, p, 16'h0000);
    chk("read data", e, h_data);
    chk("answer error", {15'h0, er}, {15'h0, h_err});
  endtask
  // Bounded wait for a channel to turn on
  task automatic wait_en(input int c);
    int n;
    n = 0;
    while (ch_en[c] !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    chk("channel on", 16'h0001, {15'h0, ch_en[c]});
  endtask
  // Clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Main sequence
  initial begin
    rst = 1'b1;
    req = '0;
    {ofs, bus_addr, pads, shclk, ch_req, vcmd, vmeas} = '0;
    fault_ext = 4'hf;
    bad_count = 0;
    checks_done = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd(CMD_ADDR_BASE, 3'h0, {9'h0, ADDR_BASE_RST}, 1'b0);
    rd(CMD_DISCH_COEF, 3'h0, COEF_RST, 1'b0);
    rd(CMD_SHARE_MASK, 3'h0, 16'h00ff, 1'b0);
    rd(CMD_PART_ID, 3'h0, 16'h5a3c, 1'b0);
    for (int p = 0; p < 8; p++) begin
      rd(CMD_LOT_NUMBER, p[2:0], {13'h0, p[2:0]}, 1'b0);
    end
    // Write lock high, share clock idle since reset
    @(posedge clk);
    pads <= 9'h004;
    repeat (4) @(posedge clk);
    rd(CMD_SHARED_PINS, 3'h0, 16'h0003, 1'b0);
    cmd(1'b1, CMD_ADDR_BASE, 3'h0, 16'h0011);
    chk("locked write", 16'h0001, {15'h0, h_err});
    repeat (40) begin
      @(posedge clk);
      shclk <= ~shclk;
    end
    rd(CMD_SHARED_PINS, 3'h0, 16'h0001, 1'b0);
    @(posedge clk);
    pads <= 9'h000;
    repeat (4) @(posedge clk);
    rd(CMD_SHARED_PINS, 3'h0, 16'h0000, 1'b0);
    repeat (2000) @(posedge clk);
    rd(CMD_SHARED_PINS, 3'h0, 16'h0002, 1'b0);
    // Base write, read-only write, unknown code
    cmd(1'b1, CMD_ADDR_BASE, 3'h0, 16'hffaa);
    rd(CMD_ADDR_BASE, 3'h0, 16'h002a, 1'b0);
    cmd(1'b1, CMD_PART_ID, 3'h0, 16'h1234);
    chk("read-only write", 16'h0001, {15'h0, h_err});
    rd(8'h10, 3'h0, 16'h0000, 1'b1);
    // Offsets 0..15, above 9 saturating
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      ofs <= i[3:0];
      bus_addr <= 7'h2a + ((i > 9) ? 7'h09 : i[6:0]);
      @(negedge clk);
      chk("device address", {9'h0, bus_addr}, {9'h0, dev_addr});
      chk("address hit", 16'h0001, {15'h0, hit});
    end
    @(posedge clk);
    bus_addr <= 7'h2a + 7'h0a;
    @(negedge clk);
    chk("address miss", 16'h0000, {15'h0, hit});
    // Two pad patterns
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      pads <= i ? 9'h009 : 9'h132;
      fault_ext <= i ? 4'he : 4'h1;
      repeat (4) @(posedge clk);
      rd(CMD_PAD_SNAPSHOT, 3'h0, i ? 16'hbc17 : 16'h7fa8, 1'b0);
      chk("power-good pin", i ? 16'h0000 : 16'h0001, {14'h0, pg_o, pg_oe});
    end
    // Channel 0 at exactly its off threshold
    @(posedge clk);
    pads <= 9'h000;
    fault_ext <= 4'hf;
    vcmd[0] <= 16'd1000;
    vmeas[0] <= 16'd500;
    ch_req[0] <= 1'b1;
    repeat (8) @(negedge clk);
    chk("held off", 16'h0000, {15'h0, ch_en[0]});
    chk("pending", 16'h0001, {15'h0, pend[0]});
    chk("alert drive", 16'h0001, {15'h0, al_oe});
    chk("fault drive", 16'h0001, {15'h0, f_oe[0]});
    rd(CMD_VENDOR_STAT, 3'h0, 16'h0001, 1'b0);
    @(posedge clk);
    vmeas[0] <= 16'd499;
    wait_en(0);
    chk("fault released", 16'h0000, {15'h0, f_oe[0]});
    cmd(1'b1, CMD_SHARE_MASK, 3'h0, 16'h0000);
    rd(CMD_SHARE_MASK, 3'h0, 16'h0000, 1'b0);
    cmd(1'b1, CMD_VENDOR_STAT, 3'h0, 16'h0001);
    rd(CMD_VENDOR_STAT, 3'h0, 16'h0000, 1'b0);
    chk("alert released", 16'h0000, {15'h0, al_oe});
    // Coefficient 1.5 on channel 2, output 1000 below its 1500 threshold
    cmd(1'b1, CMD_DISCH_COEF, 3'h2, 16'hf803);
    rd(CMD_DISCH_COEF, 3'h2, 16'hf803, 1'b0);
    @(posedge clk);
    vcmd[2] <= 16'd1000;
    vmeas[2] <= 16'd1000;
    ch_req[2] <= 1'b1;
    wait_en(2);
    chk("no pending", 16'h0000, {15'h0, pend[2]});
    // Second reset restores the base
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    rd(CMD_ADDR_BASE, 3'h0, {9'h0, ADDR_BASE_RST}, 1'b0);
    summarize();
  end
  // Host model and device
  psm_host_model host (.clk_i(clk), .req_i(req), .cmd_valid_o(c_vld), .cmd_write_o(c_wr),
    .cmd_code_o(c_code), .cmd_page_o(c_page), .cmd_wdata_o(c_wd), .rsp_valid_i(r_vld),
    .rsp_err_i(r_err), .rsp_data_i(r_data), .done_o(h_done), .err_o(h_err), .rdata_o(h_data));
  psm_regs dut (.SYS_CLK_I(clk), .SYS_RST_I(rst), .CMD_VALID_I(c_vld), .CMD_WRITE_I(c_wr),
    .CMD_CODE_I(c_code), .CMD_PAGE_I(c_page), .CMD_WDATA_I(c_wd), .RSP_VALID_O(r_vld),
    .RSP_ERR_O(r_err), .RSP_DATA_O(r_data), .ADDR_OFS_I(ofs), .BUS_ADDR_I(bus_addr),
    .DEV_ADDR_O(dev_addr), .ADDR_HIT_O(hit), .FAULT_SHARE_PIN_I(fault_ext & ~f_oe),
    .FAULT_SHARE_PIN_O(f_o), .FAULT_SHARE_PIN_OE_O(f_oe), .ALERT_N_O(al_o),
    .ALERT_N_OE_O(al_oe), .PWR_GOOD_O(pg_o), .PWR_GOOD_OE_O(pg_oe),
    .ADDRESS_SELECT_PIN_0_LVL_I(pads[6]), .ADDRESS_SELECT_PIN_0_FLOAT_I(pads[5]),
    .ADDRESS_SELECT_PIN_1_LVL_I(pads[8]), .ADDRESS_SELECT_PIN_1_FLOAT_I(pads[7]),
    .ON_OFF_INPUT_0_I(pads[3]), .ON_OFF_INPUT_1_I(pads[4]), .WRITE_LOCK_PIN_I(pads[2]),
    .SHARE_CLK_PIN_I(shclk), .PG_PULL_LOW_I(pads[1]), .ALERT_REQ_I(pads[0]),
    .CH_ON_REQ_I(ch_req), .VOUT_CMD_I(vcmd), .VOUT_MEAS_I(vmeas), .CH_ENABLE_O(ch_en),
    .DISCH_PENDING_O(pend));
endmodule
// Checker on the device ports
bind psm_regs psm_regs_asserts #(.PART_ID(PART_ID)) u_chk (.SYS_CLK_I(SYS_CLK_I),
  .SYS_RST_I(SYS_RST_I), .CMD_VALID_I(CMD_VALID_I), .CMD_WRITE_I(CMD_WRITE_I),
  .CMD_CODE_I(CMD_CODE_I), .RSP_VALID_O(RSP_VALID_O), .RSP_DATA_O(RSP_DATA_O),
  .FAULT_SHARE_PIN_O(FAULT_SHARE_PIN_O), .FAULT_SHARE_PIN_OE_O(FAULT_SHARE_PIN_OE_O),
  .ALERT_N_O(ALERT_N_O), .ALERT_N_OE_O(ALERT_N_OE_O), .PWR_GOOD_OE_O(PWR_GOOD_OE_O),
  .CH_ON_REQ_I(CH_ON_REQ_I), .CH_ENABLE_O(CH_ENABLE_O), .DISCH_PENDING_O(DISCH_PENDING_O));
